// ===== logic/ddl_load_port.sv
`timescale 1ns/1ps
// Purpose: Serial load port of a dual 12-bit converter with shared load strobe.
// Assumes: All pin inputs are asynchronous to ref_clk and slower than it by a wide margin.
// Notes: Completed words pass a FIFO before reaching the channel latches.

// Three-stage pin synchroniser that accepts a new level once stages two and three agree.
module ddl_pin_sync #(
    parameter logic IDLE = 1'b0
) (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Pin and accepted level
    input wire logic pin,
    output logic level,
    output logic nxt_level
);
    import ddl_pkg::*;

    logic [2:0] stage_ff, nxt_stage;
    logic level_ff;

    always_comb begin
        nxt_stage = {stage_ff[1:0], pin};
        nxt_level = (stage_ff[1] == stage_ff[2]) ? stage_ff[2] : level_ff;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stage_ff <= {3{IDLE}};
            level_ff <= IDLE;
        end else if (ce) begin
            stage_ff <= nxt_stage;
            level_ff <= nxt_level;
        end
    end

    assign level = level_ff;
endmodule

module ddl_load_port
    import ddl_pkg::*;
(
    // Clocking
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // Serial pins
    input wire logic shift_clk,
    input wire logic serial_data,
    input wire logic frame_sel_n,
    // Control pins
    input wire logic output_load_strobe_n,
    input wire logic clear_n,
    // Converter codes
    output logic [ddl_pkg::CODE_BITS-1:0] chan_a_code,
    output logic [ddl_pkg::CODE_BITS-1:0] chan_b_code,
    // Status
    output logic word_overflow
);
    import ddl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sclk_ff, frm_ff, dat_ff, ld_ff, clr_ff;
    logic nxt_sclk, nxt_frm, nxt_ld, nxt_clr;

    // The shift clock and data idle low, the active-low pins idle high.
    ddl_pin_sync #(.IDLE(1'b0)) u_sync_sclk (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .pin(shift_clk),
        .level(sclk_ff),
        .nxt_level(nxt_sclk)
    );
    ddl_pin_sync #(.IDLE(1'b1)) u_sync_frm (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .pin(frame_sel_n),
        .level(frm_ff),
        .nxt_level(nxt_frm)
    );
    ddl_pin_sync #(.IDLE(1'b0)) u_sync_dat (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .pin(serial_data),
        .level(dat_ff),
        .nxt_level()
    );
    ddl_pin_sync #(.IDLE(1'b1)) u_sync_ld (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .pin(output_load_strobe_n),
        .level(ld_ff),
        .nxt_level(nxt_ld)
    );
    ddl_pin_sync #(.IDLE(1'b1)) u_sync_clr (
        .clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .pin(clear_n),
        .level(clr_ff),
        .nxt_level(nxt_clr)
    );

    logic sclk_fall, frm_fall, ld_fall;
    // [R2] falling edge detect
    assign sclk_fall = sclk_ff && !nxt_sclk;
    assign frm_fall = frm_ff && !nxt_frm;
    // [R7] strobe falling edge
    assign ld_fall = ld_ff && !nxt_ld;

    // ------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------
    logic [WORD_BITS-1:0] shreg_ff, nxt_shreg;
    logic [4:0] cnt_ff, nxt_cnt;
    logic word_done;
    logic fifo_in_ready, fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;

    always_comb begin
        nxt_shreg = shreg_ff;
        nxt_cnt = cnt_ff;
        word_done = 1'b0;
        if (!clr_ff) begin
            // [R13] clear empties register
            nxt_shreg = WORD_ZERO;
            nxt_cnt = BIT_CNT_ZERO;
        end else if (frm_fall) begin
            // [R14] restart bit count
            nxt_cnt = BIT_CNT_ZERO;
        end else if (sclk_fall && !nxt_frm && cnt_ff <= BIT_CNT_LAST) begin
            // [R2] capture on falling edge
            nxt_shreg = {shreg_ff[WORD_BITS-2:0], dat_ff};
            nxt_cnt = cnt_ff + BIT_CNT_ONE;
            // [R8] sixteenth edge completes
            word_done = (cnt_ff == BIT_CNT_LAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shreg_ff <= WORD_ZERO;
            cnt_ff <= BIT_CNT_ZERO;
        end else if (ce) begin
            shreg_ff <= nxt_shreg;
            cnt_ff <= nxt_cnt;
        end
    end

    logic [FIFO_WIDTH-1:0] word_entry;
    // [R3] channel bit and code
    assign word_entry = {nxt_shreg[CHAN_SEL_POS], nxt_shreg[CODE_BITS-1:0]};

    // ------------------------------------------------------------
    // Word FIFO
    // ------------------------------------------------------------
    ddl_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst(rst || !clr_ff),
        .ce(ce),
        .in_valid(word_done),
        .in_ready(fifo_in_ready),
        .in_data(word_entry),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1),
        .out_data(fifo_out_data)
    );

    // ------------------------------------------------------------
    // Channel latches and outputs
    // ------------------------------------------------------------
    logic [CODE_BITS-1:0] lat_a_ff, lat_b_ff, out_a_ff, out_b_ff;
    logic [CODE_BITS-1:0] nxt_lat_a, nxt_lat_b, nxt_out_a, nxt_out_b;
    logic ovf_ff, nxt_ovf;

    always_comb begin
        nxt_lat_a = lat_a_ff;
        nxt_lat_b = lat_b_ff;
        nxt_out_a = out_a_ff;
        nxt_out_b = out_b_ff;
        nxt_ovf = ovf_ff || (word_done && !fifo_in_ready);
        if (fifo_out_valid) begin
            // [R3] bit 12 picks channel
            if (fifo_out_data[CODE_BITS]) begin
                nxt_lat_b = fifo_out_data[CODE_BITS-1:0];
            end else begin
                nxt_lat_a = fifo_out_data[CODE_BITS-1:0];
            end
        end
        if (!clr_ff) begin
            // [R13] latches to zero
            nxt_lat_a = CODE_ZERO;
            nxt_lat_b = CODE_ZERO;
            nxt_out_a = CODE_ZERO;
            nxt_out_b = CODE_ZERO;
            nxt_ovf = 1'b0;
        end else if (ld_fall) begin
            // [R7] simultaneous update
            nxt_out_a = nxt_lat_a;
            nxt_out_b = nxt_lat_b;
        end else if (!ld_ff) begin
            // [R8] automatic update
            nxt_out_a = nxt_lat_a;
            nxt_out_b = nxt_lat_b;
        end
        // [R6] strobe high holds outputs otherwise
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lat_a_ff <= CODE_ZERO;
            lat_b_ff <= CODE_ZERO;
            out_a_ff <= CODE_ZERO;
            out_b_ff <= CODE_ZERO;
            ovf_ff <= 1'b0;
        end else if (ce) begin
            lat_a_ff <= nxt_lat_a;
            lat_b_ff <= nxt_lat_b;
            out_a_ff <= nxt_out_a;
            out_b_ff <= nxt_out_b;
            ovf_ff <= nxt_ovf;
        end
    end

    assign chan_a_code = out_a_ff;
    assign chan_b_code = out_b_ff;
    assign word_overflow = ovf_ff;
endmodule

// ===== logic/ddl_pkg.sv
// Purpose: Constants for the dual converter serial load port.
// Assumes: Shift clock, frame select, data, load strobe and clear come from outside the clock domain.
// Notes: Word is 16 bits, most significant bit first.
// Behaviour
// [R1] The host drives frame select low before the first data bit of each transfer.
// [R2] Each data bit is captured on a falling edge of the shift clock.
// [R3] A frame is a 16-bit word whose bit 12 picks channel A when 0 and channel B when 1.
// [R4] The host sends the three ignored bits first and the least significant data bit last.
// [R5] The host returns frame select high after each 16-bit word before the next one.
// [R6] With the load strobe high one word per channel may be written and no output changes until the strobe falls.
// [R7] Both channel latches move to the outputs together on the falling edge of the load strobe.
// [R8] With the load strobe held low the selected output updates on the 16th falling shift-clock edge of the frame.
// [R9] A byte-wide host keeps frame select low across two bytes and releases it after the second.
// [R10] To load the second channel the host raises frame select and lowers it again for a new word.
// [R11] A host with an active-high framing pulse inverts it before the frame select input.
// [R12] An SPI host uses clock polarity 0 and phase 1 so data is valid at each falling edge.
// [R13] Driving clear low empties the shift register and loads both channel latches with zero codes.
// [R14] Shift-clock edges are ignored while frame select is high and the bit count restarts when it falls.
package ddl_pkg;
    localparam int WORD_BITS = 16;
    localparam int CODE_BITS = 12;
    localparam int CHAN_SEL_POS = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_WIDTH = CODE_BITS + 1;
    localparam logic [4:0] BIT_CNT_LAST = 5'h0f;
    localparam logic [4:0] BIT_CNT_ZERO = 5'h00;
    localparam logic [4:0] BIT_CNT_ONE = 5'h01;
    localparam logic [CODE_BITS-1:0] CODE_ZERO = 12'h000;
    localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
    localparam real REF_CLK_NS = 25.0;
    localparam real LINK_CLK_NS = 200.0;
endpackage

// ===== logic/ddl_fifo.sv
`timescale 1ns/1ps
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: Depth is a power of two.
// Notes: Full and empty come from the stored count.
module ddl_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 16
) (
    // Clocking
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    always_comb begin
        in_ready = (cnt_ff != DEPTH[AW:0]);
        out_valid = (cnt_ff != '0);
        out_data = mem_ff[rd_ff];
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else if (ce) begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            if (push) begin
                mem_ff[wr_ff] <= in_data;
            end
        end
    end
endmodule

// ===== tb/ddl_load_port_checker.sv
`timescale 1ns/1ps
// Purpose: Port checks for the load port.
// Assumes: Pins are far slower than ref_clk.
// Notes: Windows allow for the synchronisers.
module ddl_load_port_checker
    import ddl_pkg::*;
(
    // Clocking
    input wire logic ref_clk,
    input wire logic rst,
    // Pins
    input wire logic shift_clk,
    input wire logic frame_sel_n,
    input wire logic output_load_strobe_n,
    input wire logic clear_n,
    // Codes
    input wire logic [ddl_pkg::CODE_BITS-1:0] chan_a_code,
    input wire logic [ddl_pkg::CODE_BITS-1:0] chan_b_code
);
    import ddl_pkg::*;

    logic sclk_ff, nxt_sclk;
    logic [3:0] fall_cnt_ff, nxt_fall_cnt;
    // Counts cycles since the last falling shift clock.
    always_comb begin
        nxt_sclk = shift_clk;
        nxt_fall_cnt = fall_cnt_ff + {3'h0, fall_cnt_ff != 4'hf};
        if (rst || (sclk_ff && !shift_clk)) begin
            nxt_fall_cnt = 4'h0;
        end
    end
    always_ff @(posedge ref_clk) begin
        sclk_ff <= nxt_sclk;
        fall_cnt_ff <= nxt_fall_cnt;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence auto_run;
        (!output_load_strobe_n && clear_n) [*8];
    endsequence
    clr_zero_a: assert property (!clear_n [*7] |-> {chan_a_code, chan_b_code} == 24'h00_0000)
        else $error("codes not cleared");
    hold_out_a: assert property ((output_load_strobe_n && clear_n) [*8]
        |=> $stable({chan_a_code, chan_b_code})) else $error("code moved with strobe high");
    load_time_a: assert property ((clear_n && frame_sel_n) [*8] ##0 $changed({chan_a_code, chan_b_code})
        |-> !output_load_strobe_n && $past(output_load_strobe_n, 7)) else $error("update without strobe fall");
    idle_stable_a: assert property ((frame_sel_n && !output_load_strobe_n && clear_n) [*8]
        |=> $stable({chan_a_code, chan_b_code})) else $error("code moved while idle");
    auto_chan_a: assert property (auto_run ##0 $changed(chan_a_code) |-> $stable(chan_b_code))
        else $error("both channels moved");
    auto_time_a: assert property (auto_run ##0 $changed({chan_a_code, chan_b_code}) |-> fall_cnt_ff <= 4'h8)
        else $error("auto update late");
    fall_edge_a: assert property (auto_run ##0 $changed({chan_a_code, chan_b_code}) |-> fall_cnt_ff >= 4'h4)
        else $error("auto update early");
    auto_upd_c: cover property (auto_run ##0 $changed(chan_b_code));
    strobe_upd_c: cover property (frame_sel_n [*8] ##0 $changed(chan_a_code));
    clear_c: cover property (!clear_n [*7]);
endmodule
bind ddl_load_port ddl_load_port_checker u_ddl_load_port_checker (
    .ref_clk(ref_clk),
    .rst(rst),
    .shift_clk(shift_clk),
    .frame_sel_n(frame_sel_n),
    .output_load_strobe_n(output_load_strobe_n),
    .clear_n(clear_n),
    .chan_a_code(chan_a_code),
    .chan_b_code(chan_b_code)
);

// ===== tb/ddl_host_model.sv
`timescale 1ns/1ps
// Purpose: Host serial port model.
// Assumes: 200 ns shift clock, idle low.
// Notes: A released data line flips.
module ddl_host_model (
    // Serial pins
    output logic shift_clk,
    output logic serial_data,
    output logic frame_sel_n
);
    logic frame_pulse;
    assign frame_sel_n = ~frame_pulse;
    initial begin
        shift_clk = 1'b0;
        serial_data = 1'b0;
        frame_pulse = 1'b0;
    end
    task automatic send(input logic [15:0] w, input int n, input bit split);
        frame_pulse = 1'b1;
        #100;
        for (int i = 15; i > 15 - n; i--) begin
            shift_clk = 1'b1;
            serial_data = w[i];
            #100 shift_clk = 1'b0;
            #100;
            if (split && i == 8) #400;
        end
        frame_pulse = 1'b0;
        serial_data = ~serial_data;
        #400;
    endtask
    task automatic stray();
        repeat (3) begin
            shift_clk = 1'b1;
            #100 shift_clk = 1'b0;
            #100;
        end
    endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
// Purpose: Self-checking bench for the load port.
// Assumes: Host model drives the serial pins.
// Notes: Expected codes come from the word format.
module testbench;
    import ddl_pkg::*;
    logic ref_clk, rst, ce, output_load_strobe_n, clear_n;
    logic shift_clk, serial_data, frame_sel_n, word_overflow;
    logic [CODE_BITS-1:0] chan_a_code, chan_b_code, exp_a, exp_b, lat_a, lat_b;
    int n_fail, checks;
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ddl_load_port u_ddl_load_port (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .shift_clk(shift_clk),
        .serial_data(serial_data),
        .frame_sel_n(frame_sel_n),
        .output_load_strobe_n(output_load_strobe_n),
        .clear_n(clear_n),
        .chan_a_code(chan_a_code),
        .chan_b_code(chan_b_code),
        .word_overflow(word_overflow)
    );
    ddl_host_model u_host (
        .shift_clk(shift_clk),
        .serial_data(serial_data),
        .frame_sel_n(frame_sel_n)
    );
    task automatic cmp(input string what, input logic [CODE_BITS-1:0] e, input logic [CODE_BITS-1:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic outs(input string name);
        repeat (12) @(negedge ref_clk);
        cmp("chan_a_code", exp_a, chan_a_code);
        cmp("chan_b_code", exp_b, chan_b_code);
        $display("test %s done", name);
    endtask
    function automatic logic [WORD_BITS-1:0] mk(input bit c, input logic [CODE_BITS-1:0] v);
        return {3'h5, c, v};
    endfunction
    task automatic put(input bit c, input logic [CODE_BITS-1:0] v, input bit split);
        u_host.send(mk(c, v), WORD_BITS, split);
        {lat_a, lat_b} = c ? {lat_a, v} : {v, lat_b};
    endtask
    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #300000;
        n_fail++;
        results();
    end
    initial begin
        {rst, ce, output_load_strobe_n, clear_n} = 4'hd;
        {exp_a, exp_b, lat_a, lat_b} = 48'h0000_0000_0000;
        n_fail = 0;
        checks = 0;
        void'($urandom(32'h5172_3f46));
        repeat (8) @(negedge ref_clk);
        rst = 1'b0;
        outs("reset");
        for (int i = 0; i < 8; i++) begin
            put((i < 4) ? i[0] : 1'($urandom), (i == 0) ? 12'hfff : 12'($urandom), i == 5);
            {exp_a, exp_b} = {lat_a, lat_b};
            outs("auto");
        end
        u_host.stray();
        u_host.send(mk(1'b1, 12'h000), 10, 1'b0);
        outs("stray");
        put(1'b1, 12'ha5c, 1'b0);
        {exp_a, exp_b} = {lat_a, lat_b};
        outs("restart");
        ce = 1'b0;
        u_host.send(mk(1'b0, ~lat_a), WORD_BITS, 1'b0);
        ce = 1'b1;
        outs("freeze");
        output_load_strobe_n = 1'b1;
        put(1'b0, 12'h3c7, 1'b0);
        put(1'b1, 12'hc38, 1'b0);
        outs("hold");
        output_load_strobe_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        output_load_strobe_n = 1'b1;
        {exp_a, exp_b} = {lat_a, lat_b};
        outs("strobe");
        clear_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        {exp_a, exp_b} = 24'h00_0000;
        outs("clear");
        clear_n = 1'b1;
        cmp("word_overflow", 12'h000, {11'h000, word_overflow});
        repeat (8) @(negedge ref_clk);
        output_load_strobe_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        output_load_strobe_n = 1'b1;
        outs("clear latch");
        results();
    end
endmodule
